/* rtl/mrs_pkg.sv */
package mrs_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_OPND = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_TBL = 8'h10;
  localparam logic [7:0] ADDR_RES = 8'h14;
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 8;
  localparam int CMD_IMM_LSB = 16;
  localparam int CMD_HPEN_POS = 24;
  // status register fields
  localparam int ST_C_POS = 0;
  localparam int ST_AC_POS = 1;
  localparam int ST_Z_POS = 2;
  localparam int ST_OV_POS = 3;
  localparam int ST_SKIP_POS = 4;
  localparam int ST_BUSY_POS = 5;
  localparam int ST_MWR_POS = 6;
  // reset values and byte constants
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] OPND_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // machine cycles taken by a skipping instruction
  localparam logic [1:0] SKIP_CYCLES = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_RL_ACC = 5'h01, OP_RLC = 5'h02, OP_RLC_ACC = 5'h03,
    OP_RR = 5'h04, OP_RR_ACC = 5'h05, OP_RRC = 5'h06, OP_RRC_ACC = 5'h07,
    OP_SBC = 5'h08, OP_SBC_MEM = 5'h09, OP_SUB = 5'h0A, OP_SUB_MEM = 5'h0B,
    OP_SUB_IMM = 5'h0C, OP_DEC_SKZ = 5'h0D, OP_DEC_ACC_SKZ = 5'h0E,
    OP_INC_SKZ = 5'h0F, OP_INC_ACC_SKZ = 5'h10, OP_SKIP_BIT_SET = 5'h11,
    OP_SKIP_BIT_CLR = 5'h12, OP_SKIP_ZERO = 5'h13, OP_COPY_SKZ = 5'h14,
    OP_SET_BYTE = 5'h15, OP_SET_BIT = 5'h16, OP_SWAP = 5'h17,
    OP_SWAP_ACC = 5'h18, OP_TBL_CUR = 5'h19, OP_TBL_LAST = 5'h1A,
    OP_XOR = 5'h1B, OP_XOR_MEM = 5'h1C, OP_XOR_IMM = 5'h1D
  } mrs_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_DUMMY = 2'b10
  } mrs_state_type;
endpackage : mrs_pkg

/* rtl/mrs_datapath.sv */
`timescale 1ns/1ps
module mrs_datapath #(
  parameter int PAGE_BITS = 8,
  parameter int PROG_AW = 13
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hsel_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [PROG_AW-1:0] prog_addr_o,
  output logic prog_req_o,
  input wire logic [15:0] prog_data_i,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic skip_o
);
  import mrs_pkg::*;

  // refuse pointer widths that the table address cannot be built from
  if (PAGE_BITS < 1 || PAGE_BITS > 8 || PROG_AW <= PAGE_BITS || PROG_AW > 16 ||
      PROG_AW - PAGE_BITS > 8) begin : g_bad_widths
    $error("mrs_datapath: unsupported pointer widths");
  end

  localparam int HI_BITS = PROG_AW - PAGE_BITS;

  logic [7:0] acc_r, opnd_r, res_r, table_pointer_low_r, table_pointer_high_r, table_result_high_byte_r;
  logic [31:0] cmd_r;
  logic c_r, ac_r, z_r, ov_r, skip_r, mwr_r;
  logic [31:0] rdata_r;
  logic go_r, hpen_r;
  logic [PROG_AW-1:0] paddr_r, prog_addr_r;
  mrs_state_type state_r, state_nxt;
  logic busy_r;
  logic wr_pend_r;
  logic [7:0] waddr_r;
  logic preq_r, tbl_wait_r;

  // bus decode
  wire bus_act = hsel_i && hready_i && htrans_i[1];
  wire op_go = wr_pend_r && (waddr_r == ADDR_CMD) && !busy_r;
  mrs_op_type op;
  assign op = mrs_op_type'(cmd_r[CMD_OP_LSB +: 5]);
  wire [2:0] bsel = cmd_r[CMD_BIT_LSB +: 3];
  wire [7:0] imm = cmd_r[CMD_IMM_LSB +: 8];

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'(1) << b;
  endfunction : bit_mask

  // subtraction: a - b - borrow, with nine-bit and nibble results
  wire sub_imm = (op == OP_SUB_IMM);
  wire [7:0] sub_b = sub_imm ? imm : opnd_r;
  wire sub_brw = (op == OP_SBC || op == OP_SBC_MEM) ? ~c_r : 1'b0;
  wire [8:0] sub_full = {1'b0, acc_r} - {1'b0, sub_b} - {8'h00, sub_brw};
  wire [4:0] sub_lo = {1'b0, acc_r[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, sub_brw};
  wire [7:0] sub_res = sub_full[7:0];
  wire sub_c = ~sub_full[8];
  wire sub_ac = ~sub_lo[4];
  wire sub_ov = (acc_r[7] ^ sub_b[7]) & (acc_r[7] ^ sub_res[7]);
  // other results
  wire [7:0] dec_v = opnd_r - 8'h01;
  wire [7:0] inc_v = opnd_r + 8'h01;
  wire [7:0] xor_b = (op == OP_XOR_IMM) ? imm : opnd_r;
  wire [7:0] xor_v = acc_r ^ xor_b;
  wire [7:0] swp_v = {opnd_r[3:0], opnd_r[7:4]};
  wire sel_bit = |(opnd_r & bit_mask(bsel));

  // result/destination selection
  logic [7:0] r_val;
  logic to_acc, to_mem, skp, new_c, upd_c, upd_sub, upd_z, is_tbl;
  always_comb begin
    r_val = opnd_r;
    to_acc = 1'b0;
    to_mem = 1'b0;
    skp = 1'b0;
    new_c = c_r;
    upd_c = 1'b0;
    upd_sub = 1'b0;
    upd_z = 1'b0;
    is_tbl = 1'b0;
    unique case (op)
      OP_RL_ACC: begin r_val = {opnd_r[6:0], opnd_r[7]}; to_acc = 1'b1; end
      OP_RLC, OP_RLC_ACC: begin
        r_val = {opnd_r[6:0], c_r};
        new_c = opnd_r[7];
        upd_c = 1'b1;
        to_acc = (op == OP_RLC_ACC);
        to_mem = (op == OP_RLC);
      end
      OP_RR, OP_RR_ACC: begin
        r_val = {opnd_r[0], opnd_r[7:1]};
        to_acc = (op == OP_RR_ACC);
        to_mem = (op == OP_RR);
      end
      OP_RRC, OP_RRC_ACC: begin
        r_val = {c_r, opnd_r[7:1]};
        new_c = opnd_r[0];
        upd_c = 1'b1;
        to_acc = (op == OP_RRC_ACC);
        to_mem = (op == OP_RRC);
      end
      OP_SBC, OP_SUB, OP_SUB_IMM: begin r_val = sub_res; to_acc = 1'b1; upd_sub = 1'b1; end
      OP_SBC_MEM, OP_SUB_MEM: begin r_val = sub_res; to_mem = 1'b1; upd_sub = 1'b1; end
      OP_DEC_SKZ: begin r_val = dec_v; to_mem = 1'b1; skp = (dec_v == ZERO_BYTE); end
      OP_INC_SKZ: begin r_val = inc_v; to_mem = 1'b1; skp = (inc_v == ZERO_BYTE); end
      OP_DEC_ACC_SKZ: begin r_val = dec_v; to_acc = 1'b1; skp = (dec_v == ZERO_BYTE); end
      OP_INC_ACC_SKZ: begin r_val = inc_v; to_acc = 1'b1; skp = (inc_v == ZERO_BYTE); end
      OP_SKIP_BIT_SET: skp = sel_bit;
      OP_SKIP_BIT_CLR: skp = ~sel_bit;
      OP_SKIP_ZERO: skp = (opnd_r == ZERO_BYTE);
      OP_COPY_SKZ: begin to_acc = 1'b1; skp = (opnd_r == ZERO_BYTE); end
      OP_SET_BYTE: begin r_val = ALL_ONES; to_mem = 1'b1; end
      OP_SET_BIT: begin r_val = opnd_r | bit_mask(bsel); to_mem = 1'b1; end
      OP_SWAP: begin r_val = swp_v; to_mem = 1'b1; end
      OP_SWAP_ACC: begin r_val = swp_v; to_acc = 1'b1; end
      OP_TBL_CUR, OP_TBL_LAST: is_tbl = 1'b1;
      OP_XOR, OP_XOR_IMM: begin r_val = xor_v; to_acc = 1'b1; upd_z = 1'b1; end
      OP_XOR_MEM: begin r_val = xor_v; to_mem = 1'b1; upd_z = 1'b1; end
      default: r_val = opnd_r;
    endcase
  end

  // table address: page from high pointer, current page or last page
  wire [HI_BITS-1:0] cur_page = paddr_r[PROG_AW-1:PAGE_BITS];
  wire [HI_BITS-1:0] hi_sel = (op == OP_TBL_LAST) ? {HI_BITS{1'b1}} :
                              hpen_r ? table_pointer_high_r[HI_BITS-1:0] : cur_page;
  wire [PROG_AW-1:0] tbl_addr = {hi_sel, table_pointer_low_r[PAGE_BITS-1:0]};

  // sequencer: exec, optional dummy cycle for skips
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (op_go) state_nxt = ST_EXEC;
      ST_EXEC: begin
        if (is_tbl && !tbl_wait_r) state_nxt = ST_EXEC;
        else if (skp) state_nxt = ST_DUMMY;
        else state_nxt = ST_IDLE;
      end
      ST_DUMMY: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  wire exec_done = (state_r == ST_EXEC) && (!is_tbl || tbl_wait_r);

  // state and datapath registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      acc_r <= ACC_RST;
      c_r <= 1'b0;
      ac_r <= 1'b0;
      z_r <= 1'b0;
      ov_r <= 1'b0;
      skip_r <= 1'b0;
      mwr_r <= 1'b0;
      res_r <= ZERO_BYTE;
      table_result_high_byte_r <= ZERO_BYTE;
      preq_r <= 1'b0;
      tbl_wait_r <= 1'b0;
      prog_addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      prog_addr_r <= tbl_addr; // address stands with the request pulse
      busy_r <= (state_nxt != ST_IDLE);
      preq_r <= (state_r == ST_EXEC) && is_tbl && !tbl_wait_r;
      tbl_wait_r <= (state_r == ST_EXEC) && is_tbl && !tbl_wait_r;
      if (op_go) begin
        skip_r <= 1'b0;
        mwr_r <= 1'b0;
      end
      if (exec_done) begin
        skip_r <= skp;
        mwr_r <= to_mem || is_tbl;
        res_r <= is_tbl ? prog_data_i[7:0] : r_val;
        if (is_tbl) table_result_high_byte_r <= prog_data_i[15:8];
        if (to_acc) acc_r <= r_val;
        if (upd_c) c_r <= new_c;
        if (upd_sub) begin
          c_r <= sub_c;
          ac_r <= sub_ac;
          ov_r <= sub_ov;
        end
        if (upd_sub || upd_z) z_r <= (r_val == ZERO_BYTE);
      end else if (wr_pend_r && waddr_r == ADDR_ACC) begin
        acc_r <= hwdata_i[7:0];
      end else if (wr_pend_r && waddr_r == ADDR_STAT && !busy_r) begin
        c_r <= hwdata_i[ST_C_POS];
        ac_r <= hwdata_i[ST_AC_POS];
        z_r <= hwdata_i[ST_Z_POS];
        ov_r <= hwdata_i[ST_OV_POS];
      end
    end
  end

  // bus slave: address phase capture, write data phase, read data
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
      cmd_r <= 32'h0000_0000;
      opnd_r <= OPND_RST;
      table_pointer_low_r <= ZERO_BYTE;
      table_pointer_high_r <= ZERO_BYTE;
      hpen_r <= 1'b0;
      paddr_r <= '0;
      rdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= bus_act && hwrite_i;
      waddr_r <= haddr_i[7:0];
      if (wr_pend_r && waddr_r == ADDR_CMD && !busy_r) begin
        cmd_r <= hwdata_i;
        hpen_r <= hwdata_i[CMD_HPEN_POS];
      end
      if (wr_pend_r && waddr_r == ADDR_OPND && !busy_r) opnd_r <= hwdata_i[7:0];
      if (wr_pend_r && waddr_r == ADDR_TBL) begin
        table_pointer_low_r <= hwdata_i[7:0];
        table_pointer_high_r <= hwdata_i[15:8];
        paddr_r <= hwdata_i[16 +: PROG_AW];
      end
      if (bus_act && !hwrite_i) begin
        unique case (haddr_i[7:0])
          ADDR_CMD: rdata_r <= cmd_r;
          ADDR_OPND: rdata_r <= {24'h0, opnd_r};
          ADDR_ACC: rdata_r <= {24'h0, acc_r};
          ADDR_STAT: rdata_r <= {25'h0, mwr_r, busy_r, skip_r, ov_r, z_r, ac_r, c_r};
          ADDR_TBL: rdata_r <= {{(16 - PROG_AW){1'b0}}, paddr_r, table_pointer_high_r, table_pointer_low_r};
          ADDR_RES: rdata_r <= {16'h0, table_result_high_byte_r, res_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign hrdata_o = rdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign prog_addr_o = prog_addr_r;
  assign prog_req_o = preq_r;
  assign mem_wdata_o = res_r;
  assign mem_we_o = mwr_r;
  assign skip_o = skip_r;

  // one dummy cycle, then back to idle
  sequence s_dummy_then_idle;
    state_r == ST_DUMMY ##1 state_r == ST_IDLE;
  endsequence
  // a skipping instruction spends exactly one dummy cycle
  a_skip_dummy: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_done && skp |=> s_dummy_then_idle)
    else $error("skip did not take one dummy cycle");
  // a non-skipping instruction goes straight back to idle
  a_noskip_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_done && !skp |=> state_r == ST_IDLE)
    else $error("non-skip took extra cycle");
  // subtraction carry follows the sign of the full difference
  a_sub_carry: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_done && upd_sub |=> c_r == !$past(sub_full[8]))
    else $error("subtract carry wrong");
  // carry stays put for plain rotates and swaps
  a_rot_nocarry: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_done && (op == OP_RR || op == OP_RL_ACC || op == OP_SWAP) |=> $stable(c_r))
    else $error("carry changed by flagless op");
  // left rotate through carry loads carry from old bit 7
  a_rlc_carry: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_done && op == OP_RLC |=> c_r == $past(opnd_r[7]))
    else $error("rotate left carry wrong");
  // right rotate through carry loads carry from old bit 0
  a_rrc_carry: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_done && op == OP_RRC_ACC |=> c_r == $past(opnd_r[0]) && acc_r[7] == $past(c_r))
    else $error("rotate right carry wrong");
  // accumulator forms never raise a memory write
  a_acc_nomem: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_done && to_acc |=> !mem_we_o)
    else $error("acc form wrote memory");
  // zero flag reflects a zero xor result
  a_xor_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_done && upd_z |=> z_r == ($past(r_val) == 8'h00))
    else $error("zero flag wrong");
  // byte set writes all ones to memory
  a_set_byte: assert property (@(posedge mclk_i) disable iff (rst_i)
    exec_done && op == OP_SET_BYTE |=> mem_we_o && mem_wdata_o == 8'hFF)
    else $error("byte set wrong");
endmodule : mrs_datapath

/* tb/mrs_datapath_tb_top.sv */
`timescale 1ns/1ps
module mrs_datapath_tb_top;
  import mrs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0, hsel = 1'b0, hreadyout, hresp, prog_req, mem_we, skip;
  logic [12:0] prog_addr;
  logic [15:0] prog_data;
  logic [7:0] mem_wdata;
  int fails = 0, total_checks = 0, nreq = 0;

  // clock at 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end

  mrs_datapath i_dut (.mclk_i(clk), .rst_i(rst), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hsel_i(hsel), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .prog_addr_o(prog_addr),
    .prog_req_o(prog_req), .prog_data_i(prog_data), .mem_wdata_o(mem_wdata),
    .mem_we_o(mem_we), .skip_o(skip));

  // program memory stand-in: each word encodes its own address, answered in the cycle
  assign prog_data = {3'h5, prog_addr};
  // count program fetch requests
  always @(posedge clk) begin
    if (prog_req === 1'b1) nreq <= nreq + 1;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : chk

  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      end_of_test();
    end
  endtask : wait_rdy

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  // expected difference with flags {ov, z, ac, c}
  function automatic logic [11:0] sub_exp(input logic [7:0] a, m, input logic bin);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, a} - {1'b0, m} - {8'h0, bin};
    h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
    return {(a[7] != m[7]) && (d[7] != a[7]), d[7:0] == 8'h00, ~h[4], ~d[8], d[7:0]};
  endfunction : sub_exp

  // load operands and flags, issue a command, wait for idle and judge the outcome
  task automatic exec(input mrs_op_type op, input logic [7:0] m, a, input logic [3:0] fl,
                      input logic [2:0] bn, input logic [7:0] imm, input logic hp,
                      input logic [7:0] ev, input logic tomem, input logic [3:0] ef,
                      input logic es, input string what);
    logic [31:0] r;
    int n;
    bus(1'b1, ADDR_OPND, {24'h0, m}, r);
    bus(1'b1, ADDR_ACC, {24'h0, a}, r);
    bus(1'b1, ADDR_STAT, {28'h0, fl}, r);
    bus(1'b1, ADDR_CMD, {7'h0, hp, imm, 5'h0, bn, 3'h0, op}, r);
    n = 0;
    do begin
      bus(1'b0, ADDR_STAT, 32'h0, r);
      n++;
    end while (r[ST_BUSY_POS] !== 1'b0 && n < 20);
    if (n >= 20) begin
      fails++;
      end_of_test();
    end
    chk(r[3:0], ef, {what, " flags"});
    chk({r[ST_SKIP_POS], skip}, {es, es}, {what, " skip"});
    chk({r[ST_MWR_POS], mem_we}, {tomem, tomem}, {what, " mem write"});
    if (tomem) begin
      chk(mem_wdata, ev, {what, " mem data"});
      bus(1'b0, ADDR_RES, 32'h0, r);
      chk(r[7:0], ev, {what, " result"});
    end
    bus(1'b0, ADDR_ACC, 32'h0, r);
    chk(r[7:0], tomem ? a : ev, {what, " acc"});
  endtask : exec

  // fixed accumulator and flags, so any touch of them shows
  task automatic sk(input mrs_op_type op, input logic [7:0] m, ev, input logic tm, es);
    exec(op, m, 8'h33, 4'hA, 3'h0, 8'h00, 1'b0, ev, tm, 4'hA, es, "skip op");
  endtask : sk

  task automatic t_reset;
    logic [31:0] r;
    bus(1'b0, ADDR_ACC, 32'h0, r);
    chk(r[7:0], ACC_RST, "acc reset");
    bus(1'b0, ADDR_OPND, 32'h0, r);
    chk(r[7:0], OPND_RST, "operand reset");
    chk({skip, mem_we, hresp}, 3'h0, "outputs after reset");
    bus(1'b1, 8'h18, 32'hFFFFFFFF, r);
    bus(1'b0, 8'h18, 32'h0, r);
    chk(r, 32'h0, "unmapped read");
  endtask : t_reset

  task automatic t_rotate;
    logic [7:0] m;
    logic c;
    for (int k = 0; k < 2; k++) begin
      m = (k == 0) ? 8'h96 : 8'h69;
      c = k[0];
      exec(OP_RL_ACC, m, 8'h33, {3'h5, c}, 3'h0, 8'h00, 1'b0, {m[6:0], m[7]}, 1'b0,
           {3'h5, c}, 1'b0, "rl acc");
      exec(OP_RLC, m, 8'h33, {3'h5, c}, 3'h0, 8'h00, 1'b0, {m[6:0], c}, 1'b1,
           {3'h5, m[7]}, 1'b0, "rlc");
      exec(OP_RLC_ACC, m, 8'h33, {3'h5, c}, 3'h0, 8'h00, 1'b0, {m[6:0], c}, 1'b0,
           {3'h5, m[7]}, 1'b0, "rlc acc");
      exec(OP_RR, m, 8'h33, {3'h5, c}, 3'h0, 8'h00, 1'b0, {m[0], m[7:1]}, 1'b1,
           {3'h5, c}, 1'b0, "rr");
      exec(OP_RR_ACC, m, 8'h33, {3'h5, c}, 3'h0, 8'h00, 1'b0, {m[0], m[7:1]}, 1'b0,
           {3'h5, c}, 1'b0, "rr acc");
      exec(OP_RRC, m, 8'h33, {3'h5, c}, 3'h0, 8'h00, 1'b0, {c, m[7:1]}, 1'b1,
           {3'h5, m[0]}, 1'b0, "rrc");
      exec(OP_RRC_ACC, m, 8'h33, {3'h5, c}, 3'h0, 8'h00, 1'b0, {c, m[7:1]}, 1'b0,
           {3'h5, m[0]}, 1'b0, "rrc acc");
    end
  endtask : t_rotate

  task automatic t_sub;
    logic [16:0] v[5] = '{{8'h05, 8'h05, 1'b1}, {8'h03, 8'h05, 1'b1}, {8'h80, 8'h01, 1'b1},
                          {8'h10, 8'h01, 1'b0}, {8'h7F, 8'hFF, 1'b0}};
    logic [11:0] e0, e1;
    foreach (v[i]) begin
      e0 = sub_exp(v[i][16:9], v[i][8:1], ~v[i][0]);
      e1 = sub_exp(v[i][16:9], v[i][8:1], 1'b0);
      exec(OP_SBC, v[i][8:1], v[i][16:9], {3'h2, v[i][0]}, 3'h0, 8'h00, 1'b0, e0[7:0], 1'b0,
           e0[11:8], 1'b0, "sbc");
      exec(OP_SBC_MEM, v[i][8:1], v[i][16:9], {3'h2, v[i][0]}, 3'h0, 8'h00, 1'b0, e0[7:0],
           1'b1, e0[11:8], 1'b0, "sbc mem");
      exec(OP_SUB, v[i][8:1], v[i][16:9], {3'h2, v[i][0]}, 3'h0, 8'h00, 1'b0, e1[7:0], 1'b0,
           e1[11:8], 1'b0, "sub");
      exec(OP_SUB_MEM, v[i][8:1], v[i][16:9], {3'h2, v[i][0]}, 3'h0, 8'h00, 1'b0, e1[7:0],
           1'b1, e1[11:8], 1'b0, "sub mem");
      exec(OP_SUB_IMM, 8'hC3, v[i][16:9], {3'h2, v[i][0]}, 3'h0, v[i][8:1], 1'b0, e1[7:0],
           1'b0, e1[11:8], 1'b0, "sub imm");
    end
  endtask : t_sub

  task automatic t_skip;
    sk(OP_DEC_SKZ, 8'h01, 8'h00, 1'b1, 1'b1);
    sk(OP_DEC_SKZ, 8'h02, 8'h01, 1'b1, 1'b0);
    sk(OP_INC_SKZ, 8'hFF, 8'h00, 1'b1, 1'b1);
    sk(OP_INC_SKZ, 8'h7F, 8'h80, 1'b1, 1'b0);
    sk(OP_DEC_ACC_SKZ, 8'h01, 8'h00, 1'b0, 1'b1);
    sk(OP_INC_ACC_SKZ, 8'hFF, 8'h00, 1'b0, 1'b1);
    sk(OP_INC_ACC_SKZ, 8'h00, 8'h01, 1'b0, 1'b0);
    sk(OP_SKIP_ZERO, 8'h00, 8'h33, 1'b0, 1'b1);
    sk(OP_SKIP_ZERO, 8'h10, 8'h33, 1'b0, 1'b0);
    sk(OP_COPY_SKZ, 8'h00, 8'h00, 1'b0, 1'b1);
    sk(OP_COPY_SKZ, 8'h05, 8'h05, 1'b0, 1'b0);
    sk(OP_SET_BYTE, 8'h12, ALL_ONES, 1'b1, 1'b0);
    sk(OP_SWAP, 8'h3C, 8'hC3, 1'b1, 1'b0);
    sk(OP_SWAP_ACC, 8'h3C, 8'hC3, 1'b0, 1'b0);
  endtask : t_skip

  task automatic t_bits;
    logic [7:0] m = 8'hA5;
    for (int b = 0; b < 8; b++) begin
      exec(OP_SKIP_BIT_SET, m, 8'h33, 4'h6, b[2:0], 8'h00, 1'b0, 8'h33, 1'b0, 4'h6, m[b],
           "bit set test");
      exec(OP_SKIP_BIT_CLR, m, 8'h33, 4'h6, b[2:0], 8'h00, 1'b0, 8'h33, 1'b0, 4'h6, ~m[b],
           "bit clear test");
      exec(OP_SET_BIT, m, 8'h33, 4'h6, b[2:0], 8'h00, 1'b0, m | (8'h01 << b), 1'b1, 4'h6, 1'b0,
           "set bit");
    end
    exec(OP_XOR, 8'h5A, 8'h5A, 4'hB, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0, 4'hF, 1'b0,
         "xor");
    exec(OP_XOR_MEM, 8'h0F, 8'h33, 4'hF, 3'h0, 8'h00, 1'b0, 8'h3C, 1'b1, 4'hB, 1'b0,
         "xor mem");
    exec(OP_XOR_IMM, 8'h77, 8'h81, 4'h0, 3'h0, 8'h81, 1'b0, 8'h00, 1'b0, 4'h4, 1'b0,
         "xor imm");
  endtask : t_bits

  task automatic t_table;
    logic [31:0] r;
    logic [4:0] pg;
    int n0;
    bus(1'b1, ADDR_TBL, {3'h0, 13'h0A55, 8'h17, 8'h3C}, r);
    for (int k = 0; k < 3; k++) begin
      pg = (k == 0) ? 5'h0A : (k == 1) ? 5'h17 : 5'h1F;
      n0 = nreq;
      exec((k == 2) ? OP_TBL_LAST : OP_TBL_CUR, 8'h00, 8'h33, 4'h5, 3'h0, 8'h00, k == 1,
           8'h3C, 1'b1, 4'h5, 1'b0, "table read");
      chk(prog_addr, {pg, 8'h3C}, "program address");
      bus(1'b0, ADDR_RES, 32'h0, r);
      chk(r[15:8], {3'h5, pg}, "table high byte");
      chk(32'(nreq - n0), 32'h1, "program fetch count");
    end
  endtask : t_table

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rotate();
    t_sub();
    t_skip();
    t_bits();
    t_table();
    end_of_test();
  end
endmodule : mrs_datapath_tb_top
